// [serial_port_lane_sync_swap_test.sv]
// Self-checking bench: device and partner ends joined by one link, plus a second
// device whose receive lanes are driven by the bench. Assumes one 250 MHz clock.
`timescale 1ns/100ps
module serial_port_lane_sync_swap_test;
	localparam spl_pkg::spl_sym_t DSYM = 10'h05a;
	localparam spl_pkg::spl_sym_t VIOL = 10'h3bc;
	logic              clock, rst_n, rx_pin, tx_pin, wide;
	logic              psel, psel2, penable, pwrite;
	logic [11:0]       paddr;
	logic [31:0]       pwdata, prdata, prdata2;
	logic              pready, pready2, pslverr, pslverr2;
	logic [3:0][7:0]   even_tx_data, even_rx_data, p_tx_data, p_rx_data;
	logic              even_tx_valid, even_rx_valid, p_tx_valid, p_rx_valid;
	logic              even_link_up, odd_link_up, p_link_up;
	logic [3:0][2:0]   chan_rx_boost;
	logic [7:0]        odd_rx_data2;
	logic              odd_rx_valid2;
	spl_pkg::spl_sym_t [3:0] drv_sym;
	int                num_errors, n_compared;
	spl_link_if link();
	spl_link_if link2();
	assign link2.ptn_tx = drv_sym;

	spl_device u_spl_device (.clock, .rst_n, .rx_lane_reverse_pin(rx_pin), .tx_lane_reverse_pin(tx_pin),
		.psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .even_tx_data, .even_tx_valid,
		.odd_tx_data(8'h00), .odd_tx_valid(1'b0), .even_rx_data, .even_rx_valid, .odd_rx_data(), .odd_rx_valid(),
		.even_link_up, .odd_link_up, .chan_rx_boost, .link(link.dev));
	spl_device u_spl_device_b (.clock, .rst_n, .rx_lane_reverse_pin(rx_pin), .tx_lane_reverse_pin(tx_pin),
		.psel(psel2), .penable, .pwrite, .paddr, .pwdata, .pready(pready2), .prdata(prdata2), .pslverr(pslverr2),
		.even_tx_data, .even_tx_valid, .odd_tx_data(8'h3c), .odd_tx_valid(1'b1), .even_rx_data(), .even_rx_valid(),
		.odd_rx_data(odd_rx_data2), .odd_rx_valid(odd_rx_valid2), .even_link_up(), .odd_link_up(), .chan_rx_boost(),
		.link(link2.dev));
	spl_partner u_spl_partner (.clock, .rst_n, .wide, .tx_data(p_tx_data), .tx_valid(p_tx_valid),
		.rx_data(p_rx_data), .rx_valid(p_rx_valid), .link_up(p_link_up), .link(link.ptn));
	spl_monitor u_spl_monitor (.clock, .rst_n, .dev_tx(link.dev_tx), .ptn_tx(link.ptn_tx));

	initial clock = 1'b0;
	always #2 clock = ~clock;

	task automatic final_report;
		$display("errors %0d compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic stop(input string w);
		num_errors++;
		$display("BAD t=%0t %s", $time, w);
		final_report();
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string w);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD t=%0t %s got %h exp %h", $time, w, got, exp);
		end
	endtask

	task automatic apb(input logic b, input logic wr, input logic [11:0] a, input logic [31:0] wd,
			output logic [31:0] rd, output logic err);
		int n;
		n = 0;
		@(posedge clock);
		psel <= !b;
		psel2 <= b;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
			n++;
		end while ((b ? pready2 : pready) !== 1'b1 && n < 16);
		if ((b ? pready2 : pready) !== 1'b1) stop("no pready");
		rd = b ? prdata2 : prdata;
		err = b ? pslverr2 : pslverr;
		psel <= 1'b0;
		psel2 <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic b, input logic [11:0] a, input logic [31:0] m, input logic [31:0] e, input logic ee);
		logic [31:0] d;
		logic        err;
		apb(b, 1'b0, a, 32'h0, d, err);
		chk(d & m, e, $sformatf("read %h", a));
		chk(32'(err), 32'(ee), $sformatf("slverr %h", a));
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] wd);
		logic [31:0] d;
		logic        err;
		apb(1'b0, 1'b1, a, wd, d, err);
	endtask

	task automatic send2(input spl_pkg::spl_sym_t s, input int n);
		repeat (n) begin
			@(posedge clock);
			drv_sym <= {4{s}};
		end
	endtask

	// Alignment columns with lane D one cycle early, to force a skew step
	task automatic skew_cols;
		repeat (4) begin
			@(posedge clock);
			drv_sym <= {spl_pkg::ALIGN_SYM, {3{spl_pkg::COMMA_SYM}}};
			@(posedge clock);
			drv_sym <= {spl_pkg::COMMA_SYM, {3{spl_pkg::ALIGN_SYM}}};
			@(posedge clock);
			drv_sym <= {4{spl_pkg::COMMA_SYM}};
		end
	endtask

	task automatic do_reset(input logic rp, input logic tp, input logic w);
		rst_n <= 1'b0;
		rx_pin <= rp;
		tx_pin <= tp;
		wide <= w;
		repeat (5) @(posedge clock);
		rst_n <= 1'b1;
	endtask

	task automatic wait_up;
		int n;
		n = 0;
		while ((even_link_up !== 1'b1 || p_link_up !== 1'b1) && n < 3000) begin
			@(posedge clock);
			n++;
		end
		if (n >= 3000) stop("link not up");
	endtask

	task automatic retrain;
		int n;
		n = 0;
		while (even_link_up === 1'b1 && n < 8) begin
			@(posedge clock);
			n++;
		end
		if (n >= 8) stop("soft reset ignored");
		wait_up();
	endtask

	// Sends one column each way and compares what arrives at both user sides
	task automatic xfer(input logic [31:0] ep, input logic [31:0] ee, input logic [31:0] m);
		logic gp, ge;
		int   n;
		gp = 1'b0;
		ge = 1'b0;
		n = 0;
		@(posedge clock);
		even_tx_data <= 32'h44332211;
		p_tx_data <= 32'hd4c3b2a1;
		even_tx_valid <= 1'b1;
		p_tx_valid <= 1'b1;
		@(posedge clock);
		even_tx_valid <= 1'b0;
		p_tx_valid <= 1'b0;
		while (!(gp && ge) && n < 20) begin
			@(posedge clock);
			n++;
			if (p_rx_valid === 1'b1 && !gp) begin
				gp = 1'b1;
				chk(p_rx_data & m, ep, "partner rx");
			end
			if (even_rx_valid === 1'b1 && !ge) begin
				ge = 1'b1;
				chk(even_rx_data & m, ee, "device rx");
			end
		end
		if (!(gp && ge)) stop("column lost");
	endtask

	initial begin
		logic [2:0]  v;
		logic [31:0] d;
		logic        e;
		{rst_n, rx_pin, tx_pin, wide, psel, psel2, penable, pwrite} = 8'h00;
		{paddr, pwdata} = 44'h0;
		{even_tx_data, p_tx_data, even_tx_valid, p_tx_valid} = 66'h0;
		drv_sym = {4{DSYM}};
		num_errors = 0;
		n_compared = 0;
		@(posedge clock);
		do_reset(1'b1, 1'b0, 1'b1);
		rd(1'b0, spl_pkg::OFF_CTRL, '1, 32'h0000000a, 1'b0);
		rd(1'b0, 12'h01c, '1, 32'h0, 1'b1);
		for (int c = 0; c < 4; c++) begin
			v = 3'(c * 7 / 3);
			wr(spl_pkg::OFF_CH0 + 12'(4 * c), {29'h0, v});
			rd(1'b0, spl_pkg::OFF_CH0 + 12'(4 * c), '1, {20'h0, {1'b0, v} + 4'h1, 5'h0, v}, 1'b0);
			chk(32'(chan_rx_boost[c]), 32'(v), "boost");
		end
		send2(spl_pkg::COMMA_SYM, 127);
		send2(DSYM, 1);
		rd(1'b1, spl_pkg::OFF_STAT, '1, 32'h0, 1'b0);
		send2(VIOL, 1);
		send2(spl_pkg::COMMA_SYM, 127);
		send2(DSYM, 1);
		rd(1'b1, spl_pkg::OFF_STAT, '1, 32'h0, 1'b0);
		send2(spl_pkg::COMMA_SYM, 1);
		send2(DSYM, 1);
		rd(1'b1, spl_pkg::OFF_STAT, 32'hf, 32'hf, 1'b0);
		skew_cols();
		rd(1'b1, spl_pkg::OFF_STAT, '1, 32'h0000001f, 1'b0);
		wait_up();
		rd(1'b0, spl_pkg::OFF_STAT, '1, 32'h1f, 1'b0);
		chk(32'(odd_link_up), 32'h0, "odd up in 4x");
		xfer(32'h44332211, 32'ha1b2c3d4, '1);
		wr(spl_pkg::OFF_CTRL, 32'h0000000d);
		retrain();
		rd(1'b0, spl_pkg::OFF_CTRL, '1, 32'h00000009, 1'b0);
		xfer(32'h11223344, 32'hd4c3b2a1, '1);
		do_reset(1'b1, 1'b1, 1'b0);
		wait_up();
		rd(1'b0, spl_pkg::OFF_STAT, 32'h30, 32'h20, 1'b0);
		xfer(32'h11, 32'ha1, 32'hff);
		wr(spl_pkg::OFF_CTRL, 32'h00000007);
		repeat (1500) @(posedge clock);
		chk(32'(even_link_up), 32'h0, "swapped 1x up");
		wr(spl_pkg::OFF_CTRL, 32'h00000004);
		wait_up();
		rd(1'b0, spl_pkg::OFF_STAT, 32'h30, 32'h0, 1'b0);
		xfer(32'h11, 32'ha1, 32'hff);
		apb(1'b1, 1'b1, spl_pkg::OFF_CTRL, 32'h00000004, d, e);
		send2(spl_pkg::COMMA_SYM, 128);
		send2(DSYM, 1);
		rd(1'b1, spl_pkg::OFF_STAT, '1, 32'h0000004f, 1'b0);
		chk(32'({odd_rx_valid2, odd_rx_data2}), 32'h0000015a, "odd rx");
		chk(32'(link2.dev_tx[1]), 32'h0000003c, "odd tx");
		apb(1'b1, 1'b1, spl_pkg::OFF_CTRL, 32'h00000010, d, e);
		rd(1'b1, spl_pkg::OFF_STAT, 32'h40, 32'h0, 1'b0);
		final_report();
	end
endmodule

// [spl_device.sv]
// Even/odd port pair of one MAC: lane sync, 4x alignment, lane reversal, APB registers.
// Assumes an APB master on the clock and a link partner on spl_link_if.
//
// The register offsets and the APB register port were decided locally.
`timescale 1ns/100ps
module spl_device (
	input  wire logic                clock,
	input  wire logic                rst_n,
	input  wire logic                rx_lane_reverse_pin,
	input  wire logic                tx_lane_reverse_pin,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [11:0]         paddr,
	input  wire logic [31:0]         pwdata,
	output logic                     pready,
	output logic      [31:0]         prdata,
	output logic                     pslverr,
	input  wire logic [3:0][7:0]     even_tx_data,
	input  wire logic                even_tx_valid,
	input  wire logic [7:0]          odd_tx_data,
	input  wire logic                odd_tx_valid,
	output logic      [3:0][7:0]     even_rx_data,
	output logic                     even_rx_valid,
	output logic      [7:0]          odd_rx_data,
	output logic                     odd_rx_valid,
	output logic                     even_link_up,
	output logic                     odd_link_up,
	output logic      [3:0][2:0]     chan_rx_boost,
	spl_link_if.dev                  link
);
	logic                      swap_tx_q, swap_rx_q, wide_q, odd_pd_q, srst_q, strap_q;
	logic [3:0][2:0]           boost_q;
	logic                      pready_q, pslverr_q;
	logic [31:0]               prdata_q, rdata_d;
	spl_pkg::spl_even_st_e     st_q, st_d;
	logic [1:0]                acnt_q, col_q;
	logic [9:0]                tmr_q;
	logic                      odd_up_q, even_up_q, even_rv_q, odd_rv_q;
	logic [3:0][7:0]           even_rd_q, even_rd_d;
	logic [7:0]                odd_rd_q;
	spl_pkg::spl_sym_t [3:0]   tx_q, tx_d, ds;
	spl_pkg::spl_sym_t [3:0]   rx;
	logic [3:0]                sync, isa, isk, viol;

	// APB slave: registered answer, pready high in the first access cycle
	wire apb_setup = psel & ~penable & ~pready_q;
	wire apb_wr    = psel & penable & pready_q & pwrite;
	wire is_ctrl   = paddr == spl_pkg::OFF_CTRL;
	wire is_stat   = paddr == spl_pkg::OFF_STAT;
	wire is_ch     = paddr >= spl_pkg::OFF_CH0 && paddr < spl_pkg::OFF_CHEND && paddr[1:0] == 2'h0;
	wire [11:0] ch_off = paddr - spl_pkg::OFF_CH0;
	wire [1:0]  ch_idx = ch_off[3:2];
	wire        hit    = is_ctrl | is_stat | is_ch;

	// Swap keeps the link down in 1x width and only reverses lanes in 4x
	wire tx_sw   = swap_tx_q & wide_q;
	wire rx_sw   = swap_rx_q & wide_q;
	wire blocked = ~wide_q & (swap_tx_q | swap_rx_q);
	wire all_sync = &sync;
	wire alla     = &isa;
	wire misal    = |isa & ~alla;
	wire fb_due   = tmr_q == spl_pkg::FALLBACK_LAST;
	wire odd_up_d = ~wide_q & ~odd_pd_q & sync[1];
	wire a_col    = col_q == 2'h0;
	wire spl_pkg::spl_sym_t idle4 = a_col ? spl_pkg::ALIGN_SYM : spl_pkg::COMMA_SYM;
	wire col_data = ~|isk & ~|viol;

	assign rx = link.ptn_tx;
	assign link.dev_tx = tx_q;
	assign pready = pready_q;
	assign prdata = prdata_q;
	assign pslverr = pslverr_q;
	assign even_rx_data = even_rd_q;
	assign even_rx_valid = even_rv_q;
	assign odd_rx_data = odd_rd_q;
	assign odd_rx_valid = odd_rv_q;
	assign even_link_up = even_up_q;
	assign odd_link_up = odd_up_q;
	assign chan_rx_boost = boost_q;

	always_comb begin
		rdata_d = 32'h0;
		if (is_ctrl) begin
			rdata_d[spl_pkg::CTRL_SWAP_TX] = swap_tx_q;
			rdata_d[spl_pkg::CTRL_SWAP_RX] = swap_rx_q;
			rdata_d[spl_pkg::CTRL_WIDE] = wide_q;
			rdata_d[spl_pkg::CTRL_ODD_PD] = odd_pd_q;
		end else if (is_stat) begin
			rdata_d[3:0] = sync;
			rdata_d[spl_pkg::STAT_ALIGNED] = st_q == spl_pkg::ST_UP4;
			rdata_d[spl_pkg::STAT_FALLBACK] = st_q == spl_pkg::ST_UP1 && wide_q;
			rdata_d[spl_pkg::STAT_ODD_UP] = odd_up_q;
		end else if (is_ch) begin
			rdata_d[2:0] = boost_q[ch_idx];
			rdata_d[spl_pkg::CH_BOOST_LSB +: 4] = spl_pkg::boost_half_db(boost_q[ch_idx]);
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0;
		end else begin
			pready_q <= apb_setup;
			if (apb_setup) begin
				prdata_q <= rdata_d;
				pslverr_q <= ~hit;
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			swap_tx_q <= 1'b0;
			swap_rx_q <= 1'b0;
			wide_q <= spl_pkg::CTRL_WIDE_RST;
			odd_pd_q <= 1'b0;
			srst_q <= 1'b0;
			strap_q <= 1'b0;
			boost_q <= '0;
		end else begin
			strap_q <= 1'b1;
			srst_q <= 1'b0;
			if (!strap_q) begin
				swap_tx_q <= tx_lane_reverse_pin;
				swap_rx_q <= rx_lane_reverse_pin;
			end else if (apb_wr && is_ctrl) begin
				swap_tx_q <= pwdata[spl_pkg::CTRL_SWAP_TX];
				swap_rx_q <= pwdata[spl_pkg::CTRL_SWAP_RX];
				wide_q <= pwdata[spl_pkg::CTRL_WIDE];
				odd_pd_q <= pwdata[spl_pkg::CTRL_ODD_PD];
				srst_q <= pwdata[spl_pkg::CTRL_SRST];
			end
			if (apb_wr && is_ch) begin
				boost_q[ch_idx] <= pwdata[2:0];
			end
		end
	end

	// Per-lane sync counter and skew buffer, both on physical lanes
	for (genvar l = 0; l < spl_pkg::LANES; l++) begin : g_lane
		logic [6:0]                cnt_q;
		logic                      sync_q;
		logic [1:0]                skew_q;
		spl_pkg::spl_sym_t [2:0]   dly_q;
		wire comma = spl_pkg::sym_is(rx[l], spl_pkg::COMMA_CODE);

		assign sync[l] = sync_q;
		assign ds[l] = skew_q == 2'h0 ? rx[l] : dly_q[skew_q - 2'h1];
		assign isa[l] = spl_pkg::sym_is(ds[l], spl_pkg::ALIGN_CODE);
		assign isk[l] = ds[l][spl_pkg::SYM_K];
		assign viol[l] = ds[l][spl_pkg::SYM_VIOL];

		always_ff @(posedge clock or negedge rst_n) begin
			if (!rst_n) begin
				cnt_q <= 7'h0;
				sync_q <= 1'b0;
			end else if (srst_q || rx[l][spl_pkg::SYM_VIOL]) begin
				cnt_q <= 7'h0;
				sync_q <= 1'b0;
			end else if (!sync_q && comma) begin
				if (cnt_q == spl_pkg::SYNC_MORE) sync_q <= 1'b1;
				else cnt_q <= cnt_q + 7'h1;
			end
		end

		always_ff @(posedge clock or negedge rst_n) begin
			if (!rst_n) begin
				dly_q <= '0;
				skew_q <= 2'h0;
			end else begin
				dly_q <= {dly_q[1:0], rx[l]};
				if (srst_q) skew_q <= 2'h0;
				else if (st_q == spl_pkg::ST_ALIGN && misal && isa[l]) skew_q <= skew_q + 2'h1;
			end
		end
	end

	always_comb begin
		st_d = st_q;
		unique case (st_q)
			spl_pkg::ST_SYNC: begin
				if (wide_q && all_sync) st_d = spl_pkg::ST_ALIGN;
				else if (wide_q && fb_due) st_d = spl_pkg::ST_UP1;
				else if (!wide_q && sync[0] && !blocked) st_d = spl_pkg::ST_UP1;
			end
			spl_pkg::ST_ALIGN: begin
				if (!all_sync) st_d = spl_pkg::ST_SYNC;
				else if (alla && acnt_q == spl_pkg::ALIGN_LAST) st_d = spl_pkg::ST_UP4;
			end
			spl_pkg::ST_UP4: begin
				if (!all_sync) st_d = spl_pkg::ST_SYNC;
				else if (misal) st_d = spl_pkg::ST_ALIGN;
			end
			spl_pkg::ST_UP1: begin
				if (!sync[0] || blocked) st_d = spl_pkg::ST_SYNC;
			end
		endcase
		if (srst_q) st_d = spl_pkg::ST_SYNC;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= spl_pkg::ST_SYNC;
			acnt_q <= 2'h0;
			tmr_q <= 10'h0;
			col_q <= 2'h0;
		end else begin
			st_q <= st_d;
			col_q <= col_q + 2'h1;
			if (st_q != spl_pkg::ST_ALIGN || misal || |viol) acnt_q <= 2'h0;
			else if (alla) acnt_q <= acnt_q + 2'h1;
			if (st_q == spl_pkg::ST_SYNC && wide_q && sync[0] && !all_sync) begin
				if (!fb_due) tmr_q <= tmr_q + 10'h1;
			end else begin
				tmr_q <= 10'h0;
			end
		end
	end

	// Transmit lanes: commas until up, alignment cadence in 4x, data when up
	always_comb begin
		for (int l = 0; l < spl_pkg::LANES; l++) begin
			tx_d[l] = spl_pkg::COMMA_SYM;
			if (st_q == spl_pkg::ST_ALIGN) begin
				tx_d[l] = idle4;
			end else if (st_q == spl_pkg::ST_UP4) begin
				tx_d[l] = even_tx_valid ? spl_pkg::data_sym(even_tx_data[spl_pkg::lane_of(2'(l), tx_sw)]) : idle4;
			end else if (l == 0 && st_q == spl_pkg::ST_UP1) begin
				tx_d[l] = even_tx_valid ? spl_pkg::data_sym(even_tx_data[0]) : spl_pkg::COMMA_SYM;
			end else if (l == 1 && odd_up_q) begin
				tx_d[l] = odd_tx_valid ? spl_pkg::data_sym(odd_tx_data) : spl_pkg::COMMA_SYM;
			end
		end
	end

	always_comb begin
		even_rd_d = '0;
		for (int c = 0; c < spl_pkg::LANES; c++) begin
			if (st_q == spl_pkg::ST_UP4) even_rd_d[c] = ds[spl_pkg::lane_of(2'(c), rx_sw)][7:0];
		end
		if (st_q == spl_pkg::ST_UP1) even_rd_d[0] = rx[0][7:0];
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			tx_q <= {4{spl_pkg::COMMA_SYM}};
			even_rd_q <= '0;
			even_rv_q <= 1'b0;
			odd_rd_q <= 8'h0;
			odd_rv_q <= 1'b0;
			odd_up_q <= 1'b0;
			even_up_q <= 1'b0;
		end else begin
			tx_q <= tx_d;
			even_rd_q <= even_rd_d;
			even_rv_q <= (st_q == spl_pkg::ST_UP4 && col_data) ||
				(st_q == spl_pkg::ST_UP1 && rx[0][9:8] == 2'h0);
			odd_rd_q <= odd_up_q ? rx[1][7:0] : 8'h0;
			odd_rv_q <= odd_up_q && rx[1][9:8] == 2'h0;
			odd_up_q <= odd_up_d;
			even_up_q <= st_q == spl_pkg::ST_UP4 || st_q == spl_pkg::ST_UP1;
		end
	end
endmodule

// [spl_link_if.sv]
// Serial link between the switch MAC lanes and its link partner.
// Each lane carries one decoded code group per clock; the bench joins both ends.
`timescale 1ns/100ps
interface spl_link_if;
	spl_pkg::spl_sym_t [3:0] dev_tx;
	spl_pkg::spl_sym_t [3:0] ptn_tx;

	modport dev (output dev_tx, input ptn_tx);
	modport ptn (output ptn_tx, input dev_tx);
endinterface

// [spl_monitor.sv]
// Wire checker for the link joining the device end and the partner end.
// Assumes the bench hands it the link signals and the shared clock and reset.
`timescale 1ns/100ps
module spl_monitor (
	input wire logic                    clock,
	input wire logic                    rst_n,
	input wire spl_pkg::spl_sym_t [3:0] dev_tx,
	input wire spl_pkg::spl_sym_t [3:0] ptn_tx
);
	localparam spl_pkg::spl_sym_t C = spl_pkg::COMMA_SYM;
	localparam spl_pkg::spl_sym_t A = spl_pkg::ALIGN_SYM;
	logic [7:0] dev_cm_q, ptn_cm_q;
	logic [2:0] dev_col_q, ptn_col_q, cyc_q;
	wire        dev_all_c = dev_tx == {4{C}};
	wire        dev_all_a = dev_tx == {4{A}};
	wire        dev_any_a = dev_tx[0] == A || dev_tx[1] == A || dev_tx[2] == A || dev_tx[3] == A;
	wire        ptn_all_a = ptn_tx == {4{A}};
	wire        ptn_any_a = ptn_tx[0] == A || ptn_tx[1] == A || ptn_tx[2] == A || ptn_tx[3] == A;
	wire        dev_d3    = dev_tx[3][9:8] == 2'h0 && |dev_tx[3][7:0];
	wire        ptn_d3    = ptn_tx[3][9:8] == 2'h0 && |ptn_tx[3][7:0];
	// Clean commas on lane A saturate at 128; a code error clears the count
	wire [7:0]  dev_cm_d  = dev_tx[0][9] ? 8'h00 : dev_cm_q + 8'(dev_tx[0] == C && !dev_cm_q[7]);
	wire [7:0]  ptn_cm_d  = ptn_tx[0][9] ? 8'h00 : ptn_cm_q + 8'(ptn_tx[0] == C && !ptn_cm_q[7]);
	// Whole alignment columns saturate at 4; a partial column clears the count
	wire [2:0]  dev_col_d = (dev_any_a && !dev_all_a) ? 3'h0 : dev_col_q + 3'(dev_all_a && !dev_col_q[2]);
	wire [2:0]  ptn_col_d = (ptn_any_a && !ptn_all_a) ? 3'h0 : ptn_col_q + 3'(ptn_all_a && !ptn_col_q[2]);
	wire [2:0]  cyc_d     = cyc_q + 3'(cyc_q != 3'h7);

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			{dev_cm_q, ptn_cm_q, dev_col_q, ptn_col_q, cyc_q} <= 25'h0;
		end else begin
			{dev_cm_q, ptn_cm_q, dev_col_q, ptn_col_q, cyc_q} <= {dev_cm_d, ptn_cm_d, dev_col_d, ptn_col_d, cyc_d};
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	property p_dev_reset_comma; cyc_q < 3'h2 |-> dev_all_c; endproperty
	property p_ptn_reset_comma; cyc_q < 3'h2 |-> ptn_tx[0] == C; endproperty
	property p_dev_quiet; !ptn_cm_q[7] |-> dev_all_c; endproperty
	property p_ptn_quiet; !dev_cm_q[7] |-> ptn_tx[0] == C; endproperty
	property p_dev_whole_col; dev_any_a |-> dev_all_a; endproperty
	property p_dev_col_gap; dev_all_a |=> !dev_any_a [*3]; endproperty
	property p_dev_data_aligned; dev_d3 |-> ptn_col_q == 3'h4; endproperty
	property p_ptn_data_aligned; ptn_d3 |-> dev_col_q == 3'h4; endproperty

	a_dev_reset_comma: assert property (p_dev_reset_comma) else $error("device not sending commas after reset");
	a_ptn_reset_comma: assert property (p_ptn_reset_comma) else $error("partner not sending commas after reset");
	a_dev_quiet: assert property (p_dev_quiet) else $error("device left commas before lane A sync");
	a_ptn_quiet: assert property (p_ptn_quiet) else $error("partner left commas before lane sync");
	a_dev_whole_col: assert property (p_dev_whole_col) else $error("device sent a partial alignment column");
	a_dev_col_gap: assert property (p_dev_col_gap) else $error("device alignment columns too close");
	a_dev_data_aligned: assert property (p_dev_data_aligned) else $error("device sent 4x data unaligned");
	a_ptn_data_aligned: assert property (p_ptn_data_aligned) else $error("partner sent 4x data unaligned");

	c_align: cover property (dev_all_a);
	c_dev_data: cover property (dev_d3);
	c_ptn_data: cover property (ptn_d3);
endmodule

// [spl_partner.sv]
// Link partner port: 4x or 1x, lane sync and alignment without skew correction.
// Assumes the device end on spl_link_if; lane 0 faces the device's lane A.
`timescale 1ns/100ps
module spl_partner (
	input  wire logic                clock,
	input  wire logic                rst_n,
	input  wire logic                wide,
	input  wire logic [3:0][7:0]     tx_data,
	input  wire logic                tx_valid,
	output logic      [3:0][7:0]     rx_data,
	output logic                     rx_valid,
	output logic                     link_up,
	spl_link_if.ptn                  link
);
	spl_pkg::spl_ptn_st_e      st_q;
	logic [1:0]                acnt_q, col_q;
	logic [3:0]                sync, isa;
	spl_pkg::spl_sym_t [3:0]   tx_q, tx_d, rx;
	logic [3:0][7:0]           rd_q;
	logic                      rv_q, up_q;

	assign rx = link.dev_tx;
	assign link.ptn_tx = tx_q;
	assign rx_data = rd_q;
	assign rx_valid = rv_q;
	assign link_up = up_q;

	wire used_sync = wide ? &sync : sync[0];
	wire alla  = &isa;
	wire misal = |isa & ~alla;
	wire spl_pkg::spl_sym_t idle4 = col_q == 2'h0 ? spl_pkg::ALIGN_SYM : spl_pkg::COMMA_SYM;

	for (genvar l = 0; l < spl_pkg::LANES; l++) begin : g_lane
		logic [6:0] cnt_q;
		logic       sync_q;
		wire comma = spl_pkg::sym_is(rx[l], spl_pkg::COMMA_CODE);

		assign sync[l] = sync_q;
		assign isa[l] = spl_pkg::sym_is(rx[l], spl_pkg::ALIGN_CODE);

		always_ff @(posedge clock or negedge rst_n) begin
			if (!rst_n) begin
				cnt_q <= 7'h0;
				sync_q <= 1'b0;
			end else if (rx[l][spl_pkg::SYM_VIOL]) begin
				cnt_q <= 7'h0;
				sync_q <= 1'b0;
			end else if (!sync_q && comma) begin
				if (cnt_q == spl_pkg::SYNC_MORE) sync_q <= 1'b1;
				else cnt_q <= cnt_q + 7'h1;
			end
		end
	end

	always_comb begin
		for (int l = 0; l < spl_pkg::LANES; l++) begin
			tx_d[l] = spl_pkg::COMMA_SYM;
			if (wide && st_q != spl_pkg::PT_SYNC) begin
				tx_d[l] = (st_q == spl_pkg::PT_UP && tx_valid) ? spl_pkg::data_sym(tx_data[l]) : idle4;
			end else if (!wide && l != 0) begin
				// A 1x partner has no lanes B to D, so they must never look synchronizable
				tx_d[l] = spl_pkg::data_sym(8'h00);
			end else if (!wide && l == 0 && st_q == spl_pkg::PT_UP && tx_valid) begin
				tx_d[l] = spl_pkg::data_sym(tx_data[0]);
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= spl_pkg::PT_SYNC;
			acnt_q <= 2'h0;
			col_q <= 2'h0;
		end else begin
			col_q <= col_q + 2'h1;
			// Count survives the idle gaps between alignment columns
			if (st_q != spl_pkg::PT_ALIGN || misal) acnt_q <= 2'h0;
			if (!used_sync) begin
				st_q <= spl_pkg::PT_SYNC;
			end else begin
				unique case (st_q)
					spl_pkg::PT_SYNC: st_q <= wide ? spl_pkg::PT_ALIGN : spl_pkg::PT_UP;
					spl_pkg::PT_ALIGN: begin
						if (alla && acnt_q == spl_pkg::ALIGN_LAST) st_q <= spl_pkg::PT_UP;
						else if (alla) acnt_q <= acnt_q + 2'h1;
					end
					spl_pkg::PT_UP: if (wide && misal) st_q <= spl_pkg::PT_ALIGN;
					default: st_q <= spl_pkg::PT_SYNC;
				endcase
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			tx_q <= {4{spl_pkg::COMMA_SYM}};
			rd_q <= '0;
			rv_q <= 1'b0;
			up_q <= 1'b0;
		end else begin
			tx_q <= tx_d;
			for (int l = 0; l < spl_pkg::LANES; l++) rd_q[l] <= (wide || l == 0) ? rx[l][7:0] : 8'h0;
			rv_q <= st_q == spl_pkg::PT_UP && (wide ? ~|{rx[3][9:8], rx[2][9:8], rx[1][9:8], rx[0][9:8]} :
				rx[0][9:8] == 2'h0);
			up_q <= st_q == spl_pkg::PT_UP;
		end
	end
endmodule

// [spl_pkg.sv]
// Shared constants, symbol layout and helpers for the lane sync and swap pair.
// Assumes one 250 MHz clock; link symbols are already 8b/10b decoded code groups.
package spl_pkg;
	localparam int LANES = 4;
	typedef logic [9:0] spl_sym_t;
	localparam int SYM_VIOL = 9;
	localparam int SYM_K    = 8;
	localparam logic [7:0] COMMA_CODE = 8'hbc;
	localparam logic [7:0] ALIGN_CODE = 8'h7c;
	localparam spl_sym_t COMMA_SYM = 10'h1bc;
	localparam spl_sym_t ALIGN_SYM = 10'h17c;
	localparam logic [6:0] SYNC_MORE  = 7'h7f;
	localparam logic [1:0] ALIGN_LAST = 2'h3;
	localparam int CLK_NS      = 4;
	localparam int FALLBACK_NS = 4000;
	localparam int FALLBACK_CYC = (FALLBACK_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [9:0] FALLBACK_LAST = 10'(FALLBACK_CYC - 1);
	localparam logic [11:0] OFF_CTRL = 12'h000;
	localparam logic [11:0] OFF_STAT = 12'h004;
	localparam logic [11:0] OFF_CH0  = 12'h008;
	localparam logic [11:0] OFF_CHEND = 12'h018;
	localparam int CTRL_SWAP_TX = 0;
	localparam int CTRL_SWAP_RX = 1;
	localparam int CTRL_SRST    = 2;
	localparam int CTRL_WIDE    = 3;
	localparam int CTRL_ODD_PD  = 4;
	localparam logic CTRL_WIDE_RST = 1'h1;
	localparam int STAT_ALIGNED  = 4;
	localparam int STAT_FALLBACK = 5;
	localparam int STAT_ODD_UP   = 6;
	localparam int CH_BOOST_LSB  = 8;
	typedef enum logic [1:0] {ST_SYNC, ST_ALIGN, ST_UP4, ST_UP1} spl_even_st_e;
	typedef enum logic [1:0] {PT_SYNC, PT_ALIGN, PT_UP} spl_ptn_st_e;

	function automatic logic sym_is(spl_sym_t s, logic [7:0] code);
		return !s[SYM_VIOL] && s[SYM_K] && s[7:0] == code;
	endfunction

	function automatic logic [1:0] lane_of(logic [1:0] idx, logic rev);
		return rev ? 2'h3 - idx : idx;
	endfunction

	function automatic spl_sym_t data_sym(logic [7:0] d);
		return {2'h0, d};
	endfunction

	function automatic logic [3:0] boost_half_db(logic [2:0] v);
		return {1'h0, v} + 4'h1;
	endfunction
endpackage
